/* File: include/rphc_pkg.sv */
// Constants, field layouts and state types of the packet framer.
// Assumes a 32-bit APB host; every register takes one aligned word.
// Function
// - Broadcast FFh also passes an enabled byte check
// - Broadcast enable field selects bytes, one bit each
// - Check field selects compared bytes; zero disables
// - Header length acts only with packet handling
// - Header 0..4 bytes, highest-numbered byte first
// - Fixed-length flag omits length byte from header
// - Marker length 1..4 bytes, byte 3 first
// - Preamble length is nine-bit nibble count
// - Preamble length zero behaves as one nibble
// - Preamble length resets to eight nibbles
// - Detection threshold sets nibbles before preamble found
// - Marker bytes reset to 2d, d4, 00
// - Framing only with handling enabled, FIFO mode
// - Only mask-enabled bits compared in header check
// - Fixed length receive uses local length register
package rphc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_HDR_CHECK = 10'h032;
  localparam logic [9:0] IDX_HDR_LEN = 10'h033;
  localparam logic [9:0] IDX_PRE_LOW = 10'h034;
  localparam logic [9:0] IDX_PRE_DET = 10'h035;
  localparam logic [9:0] IDX_SYNC3 = 10'h036;
  localparam logic [9:0] IDX_SYNC2 = 10'h037;
  localparam logic [9:0] IDX_SYNC1 = 10'h038;
  localparam logic [9:0] IDX_FRAME_CTRL = 10'h060;
  localparam logic [9:0] IDX_SYNC0 = 10'h061;
  localparam logic [9:0] IDX_PKT_LEN = 10'h062;
  localparam logic [9:0] IDX_TX_HDR = 10'h063;
  localparam logic [9:0] IDX_CHK_HDR = 10'h064;
  localparam logic [9:0] IDX_HDR_MASK = 10'h065;
  localparam logic [9:0] IDX_STATUS = 10'h066;
  localparam logic [9:0] IDX_RX_HDR = 10'h067;
  // Reset values
  localparam logic [7:0] RST_HDR_CHECK = 8'h00;
  localparam logic [7:0] RST_HDR_LEN = 8'h00;
  localparam logic [7:0] RST_PRE_LOW = 8'h08;
  localparam logic [7:0] RST_PRE_DET = 8'h2a;
  localparam logic [7:0] RST_SYNC3 = 8'h2d;
  localparam logic [7:0] RST_SYNC2 = 8'hd4;
  localparam logic [7:0] RST_SYNC1 = 8'h00;
  localparam logic [7:0] RST_SYNC0 = 8'h00;
  // Field positions
  localparam int BCEN_LSB = 4;
  localparam int HDCH_LSB = 0;
  localparam int HDLEN_LSB = 4;
  localparam int FIXLEN_BIT = 3;
  localparam int SYNCLEN_LSB = 1;
  localparam int PRE_MSB_BIT = 0;
  localparam int PREATH_LSB = 3;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int ST_RX_OK = 0;
  localparam int ST_HDR_ERR = 1;
  localparam int ST_SENT = 2;
  // Encodings
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [7:0] BCAST_BYTE = 8'hff;
  localparam logic [3:0] PRE_NIB = 4'ha;
  localparam logic [2:0] HDR_MAX = 3'h4;
  localparam int FIFO_DEPTH = 4;
  localparam int BYTE_W = 8;
  // State types
  typedef enum logic [2:0] {
    ts_idle, ts_pre, ts_sync, ts_hdr, ts_len, ts_data
  } rphc_tx_st_t;
  typedef enum logic [2:0] {
    rs_hunt, rs_sync, rs_hdr, rs_chk, rs_len, rs_data
  } rphc_rx_st_t;
  // Byte i of a four-byte word
  function automatic logic [7:0] byte_sel(input logic [31:0] w,
                                          input logic [1:0] i);
    byte_sel = w[{i, 3'b000} +: 8];
  endfunction : byte_sel
endpackage : rphc_pkg

/* File: verilog/rphc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, async active-low reset.
`timescale 1ns/10ps
module rphc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // Full and empty from pointers with a wrap bit
  assign in_ready = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r[AW-1:0]];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule : rphc_fifo

/* File: verilog/rphc_hdr_check.sv */
// Received header comparison against check bytes, mask and broadcast.
// Assumes all inputs are stable registers of the same clock.
`timescale 1ns/10ps
module rphc_hdr_check import rphc_pkg::*; (
  // Header words, byte 3 in the top bits
  input wire logic [31:0] rx_header,
  input wire logic [31:0] check_header,
  input wire logic [31:0] header_mask,
  // Per-byte selects
  input wire logic [3:0] check_sel,
  input wire logic [3:0] bcast_sel,
  // Result
  output logic pass
);
  // Every selected byte must match under mask or be broadcast
  always_comb begin
    logic [7:0] diff;
    diff = 8'h00;
    pass = 1'b1;
    for (int i = 0; i < 4; i++) begin
      diff = (byte_sel(rx_header, 2'(i)) ^ byte_sel(check_header, 2'(i)))
             & byte_sel(header_mask, 2'(i));
      if (check_sel[i] && diff != 8'h00
          && !(bcast_sel[i] && byte_sel(rx_header, 2'(i)) == BCAST_BYTE))
      begin
        pass = 1'b0;
      end
    end
  end
endmodule : rphc_hdr_check

/* File: verilog/rphc_framer.sv */
// Packet framer: APB registers, transmit nibble framer, receive parser.
// Assumes the modulator and demodulator run on pclk and move nibbles.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module rphc_framer import rphc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit payload bytes
  input wire logic [7:0] tx_data,
  input wire logic tx_data_valid,
  output logic tx_data_ready,
  input wire logic tx_start,
  // Nibbles to the modulator
  output logic [3:0] tx_nib,
  output logic tx_nib_valid,
  input wire logic tx_nib_ready,
  // Nibbles from the demodulator
  input wire logic [3:0] rx_nib,
  input wire logic rx_nib_valid,
  input wire logic rx_restart,
  // Received payload bytes
  output logic [7:0] rx_data,
  output logic rx_data_valid
);
  logic [7:0] hdr_check_r, hdr_len_r, pre_low_r, pre_det_r;
  logic [7:0] sync3_r, sync2_r, sync1_r, sync0_r, pkt_len_r;
  logic [3:0] frame_ctrl_r;
  logic [31:0] tx_hdr_r, chk_hdr_r, hdr_mask_r, rx_hdr_r;
  logic [2:0] flags_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_mux;
  logic hit, wr_en;
  logic [9:0] idx;
  logic tx_auto, rx_auto, fixlen;
  logic [2:0] hdr_bytes;
  logic [1:0] synclen;
  logic [8:0] pre_nibs;
  logic [4:0] det_thr;
  logic [31:0] sync_word, sync_exp, sync_mask;
  rphc_tx_st_t tx_st_r;
  rphc_rx_st_t rx_st_r;
  logic [8:0] tx_cnt_r;
  logic [1:0] tx_idx_r, rx_idx_r;
  logic tx_half_r, rx_half_r, tx_was_busy_r;
  logic [3:0] tx_nib_r, rx_hi_r;
  logic tx_nib_valid_r;
  logic [7:0] tx_cur;
  logic tx_have, tx_take, tx_step;
  logic [7:0] fifo_dout;
  logic fifo_valid, fifo_pop;
  logic [4:0] rx_pcnt_r;
  logic [31:0] rx_shift_r, rx_shift_nxt;
  logic [7:0] rx_len_r, rx_cnt_r, rx_byte, rx_data_r;
  logic rx_data_valid_r, rx_byte_done, hdr_pass;
  logic rx_ok_set, hdr_err_set, sent_set;

  // Configuration decode
  assign tx_auto = frame_ctrl_r[CTRL_TX_EN]
    && frame_ctrl_r[CTRL_MODE_LSB +: 2] == MODE_FIFO;
  assign rx_auto = frame_ctrl_r[CTRL_RX_EN]
    && frame_ctrl_r[CTRL_MODE_LSB +: 2] == MODE_FIFO;
  assign hdr_bytes = (hdr_len_r[HDLEN_LSB +: 3] > HDR_MAX) ? HDR_MAX
                     : hdr_len_r[HDLEN_LSB +: 3];
  assign fixlen = hdr_len_r[FIXLEN_BIT];
  assign synclen = hdr_len_r[SYNCLEN_LSB +: 2];
  assign pre_nibs = ({hdr_len_r[PRE_MSB_BIT], pre_low_r} == 9'h000)
    ? 9'h001 : {hdr_len_r[PRE_MSB_BIT], pre_low_r};
  assign det_thr = (pre_det_r[PREATH_LSB +: 5] == 5'h00) ? 5'h01
                   : pre_det_r[PREATH_LSB +: 5];
  assign sync_word = {sync3_r, sync2_r, sync1_r, sync0_r};
  // Marker bytes 3 downward, aligned to the low end
  assign sync_exp = sync_word >> {~synclen, 3'b000};
  assign sync_mask = 32'hffffffff >> {~synclen, 3'b000};

  // APB decode; zero wait states
  assign idx = paddr[11:2];
  assign wr_en = psel && penable && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_r;
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h00000000;
    case (idx)
      IDX_HDR_CHECK: rd_mux[7:0] = hdr_check_r;
      IDX_HDR_LEN: rd_mux[7:0] = hdr_len_r;
      IDX_PRE_LOW: rd_mux[7:0] = pre_low_r;
      IDX_PRE_DET: rd_mux[7:0] = pre_det_r;
      IDX_SYNC3: rd_mux[7:0] = sync3_r;
      IDX_SYNC2: rd_mux[7:0] = sync2_r;
      IDX_SYNC1: rd_mux[7:0] = sync1_r;
      IDX_SYNC0: rd_mux[7:0] = sync0_r;
      IDX_FRAME_CTRL: rd_mux[3:0] = frame_ctrl_r;
      IDX_PKT_LEN: rd_mux[7:0] = pkt_len_r;
      IDX_TX_HDR: rd_mux = tx_hdr_r;
      IDX_CHK_HDR: rd_mux = chk_hdr_r;
      IDX_HDR_MASK: rd_mux = hdr_mask_r;
      IDX_STATUS: rd_mux[4:0] = {rx_st_r != rs_hunt,
                                 tx_st_r != ts_idle, flags_r};
      IDX_RX_HDR: rd_mux = rx_hdr_r;
      default: hit = 1'b0;
    endcase
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  // Software-written configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_check_r <= RST_HDR_CHECK;
      hdr_len_r <= RST_HDR_LEN;
      pre_low_r <= RST_PRE_LOW;
      pre_det_r <= RST_PRE_DET;
      sync3_r <= RST_SYNC3;
      sync2_r <= RST_SYNC2;
      sync1_r <= RST_SYNC1;
      sync0_r <= RST_SYNC0;
      frame_ctrl_r <= 4'h0;
      pkt_len_r <= 8'h00;
      tx_hdr_r <= 32'h00000000;
      chk_hdr_r <= 32'h00000000;
      hdr_mask_r <= 32'h00000000;
    end else if (wr_en) begin
      case (idx)
        IDX_HDR_CHECK: hdr_check_r <= pwdata[7:0];
        IDX_HDR_LEN: hdr_len_r <= {1'b0, pwdata[6:0]}; // Bit 7 reserved
        IDX_PRE_LOW: pre_low_r <= pwdata[7:0];
        IDX_PRE_DET: pre_det_r <= pwdata[7:0];
        IDX_SYNC3: sync3_r <= pwdata[7:0];
        IDX_SYNC2: sync2_r <= pwdata[7:0];
        IDX_SYNC1: sync1_r <= pwdata[7:0];
        IDX_SYNC0: sync0_r <= pwdata[7:0];
        IDX_FRAME_CTRL: frame_ctrl_r <= pwdata[3:0];
        IDX_PKT_LEN: pkt_len_r <= pwdata[7:0];
        IDX_TX_HDR: tx_hdr_r <= pwdata;
        IDX_CHK_HDR: chk_hdr_r <= pwdata;
        IDX_HDR_MASK: hdr_mask_r <= pwdata;
        default: ;
      endcase
    end
  end

  // Sticky status flags; write one clears, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 3'h0;
    end else begin
      flags_r <= (flags_r & ~((wr_en && idx == IDX_STATUS) ? pwdata[2:0]
                  : 3'h0)) | {sent_set, hdr_err_set, rx_ok_set};
    end
  end

  // Transmit payload buffer
  rphc_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_data(tx_data),
    .in_valid(tx_data_valid),
    .in_ready(tx_data_ready),
    .out_data(fifo_dout),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Byte presented by the current transmit field
  always_comb begin
    tx_have = 1'b1;
    tx_cur = 8'h00;
    case (tx_st_r)
      ts_pre: tx_cur = {PRE_NIB, PRE_NIB};
      ts_sync: tx_cur = byte_sel(sync_word, ~tx_idx_r);
      ts_hdr: tx_cur = byte_sel(tx_hdr_r, ~tx_idx_r);
      ts_len: tx_cur = pkt_len_r;
      ts_data: begin
        tx_cur = fifo_dout;
        tx_have = fifo_valid;
      end
      default: tx_have = 1'b0;
    endcase
  end
  assign tx_take = !tx_nib_valid_r || tx_nib_ready;
  assign tx_step = tx_take && tx_have;
  assign fifo_pop = tx_step && tx_st_r == ts_data && tx_half_r;
  assign sent_set = tx_was_busy_r && tx_st_r == ts_idle;

  // Transmit sequencer: preamble, marker, header, length, payload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= ts_idle;
      tx_cnt_r <= 9'h000;
      tx_idx_r <= 2'h0;
      tx_half_r <= 1'b0;
    end else begin
      case (tx_st_r)
        ts_idle: begin
          tx_cnt_r <= 9'h000;
          tx_idx_r <= 2'h0;
          tx_half_r <= 1'b0;
          if (tx_start) begin
            tx_st_r <= tx_auto ? ts_pre : ts_data;
          end
        end
        ts_pre: if (tx_step) begin
          tx_cnt_r <= tx_cnt_r + 9'h001;
          if (tx_cnt_r == pre_nibs - 9'h001) begin
            tx_st_r <= ts_sync;
          end
        end
        default: if (tx_step) begin
          tx_half_r <= !tx_half_r;
          if (tx_half_r) begin
            tx_idx_r <= tx_idx_r + 2'h1;
            if (tx_st_r == ts_sync && tx_idx_r == synclen) begin
              tx_idx_r <= 2'h0;
              tx_st_r <= (hdr_bytes != 3'h0) ? ts_hdr
                : fixlen ? ((pkt_len_r == 8'h00) ? ts_idle : ts_data)
                : ts_len;
            end else if (tx_st_r == ts_hdr
                         && {1'b0, tx_idx_r} == hdr_bytes - 3'h1) begin
              tx_st_r <= fixlen ? ((pkt_len_r == 8'h00) ? ts_idle
                                   : ts_data) : ts_len;
            end else if (tx_st_r == ts_len) begin
              tx_cnt_r <= 9'h000;
              tx_st_r <= (pkt_len_r == 8'h00) ? ts_idle : ts_data;
            end else if (tx_st_r == ts_data) begin
              tx_cnt_r <= tx_cnt_r + 9'h001;
              if (tx_auto && tx_cnt_r[7:0] == pkt_len_r - 8'h01) begin
                tx_st_r <= ts_idle;
              end
            end
            if (tx_st_r == ts_sync && tx_idx_r == synclen) begin
              tx_cnt_r <= 9'h000;
            end
          end
        end else if (tx_st_r == ts_data && !tx_auto && !fifo_valid
                     && !tx_half_r) begin
          tx_st_r <= ts_idle; // Raw mode ends when the buffer runs dry
        end
      endcase
    end
  end

  // Output nibble stage, high nibble first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_nib_r <= 4'h0;
      tx_nib_valid_r <= 1'b0;
      tx_was_busy_r <= 1'b0;
    end else begin
      tx_was_busy_r <= (tx_st_r != ts_idle) && tx_auto;
      if (tx_take) begin
        tx_nib_valid_r <= tx_step;
        if (tx_step) begin
          tx_nib_r <= tx_half_r ? tx_cur[3:0] : tx_cur[7:4];
        end
      end
    end
  end
  assign tx_nib = tx_nib_r;
  assign tx_nib_valid = tx_nib_valid_r;

  // Receive byte assembly and header check
  assign rx_byte = {rx_hi_r, rx_nib};
  assign rx_byte_done = rx_nib_valid && rx_half_r;
  assign rx_shift_nxt = {rx_shift_r[27:0], rx_nib};
  rphc_hdr_check u_hdr_check (
    .rx_header(rx_hdr_r),
    .check_header(chk_hdr_r),
    .header_mask(hdr_mask_r),
    .check_sel(hdr_check_r[HDCH_LSB +: 4]),
    .bcast_sel(hdr_check_r[BCEN_LSB +: 4]),
    .pass(hdr_pass)
  );
  assign hdr_err_set = rx_st_r == rs_chk && !hdr_pass;
  assign rx_ok_set = rx_auto && ((rx_st_r == rs_chk && hdr_pass && fixlen
    && pkt_len_r == 8'h00) || (rx_st_r == rs_len && rx_byte_done
    && rx_byte == 8'h00) || (rx_st_r == rs_data && rx_byte_done
    && rx_cnt_r == rx_len_r - 8'h01));

  // Receive sequencer: detect, marker hunt, header, length, payload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= rs_hunt;
      rx_pcnt_r <= 5'h00;
      rx_shift_r <= 32'h00000000;
      rx_idx_r <= 2'h0;
      rx_half_r <= 1'b0;
      rx_hi_r <= 4'h0;
      rx_len_r <= 8'h00;
      rx_cnt_r <= 8'h00;
      rx_hdr_r <= 32'h00000000;
    end else if (rx_restart) begin
      rx_st_r <= rs_hunt;
      rx_pcnt_r <= 5'h00;
    end else begin
      if (rx_nib_valid && rx_st_r != rs_hunt && rx_st_r != rs_sync) begin
        rx_half_r <= !rx_half_r;
        rx_hi_r <= rx_nib;
      end
      case (rx_st_r)
        rs_hunt: if (rx_nib_valid) begin
          if (rx_nib != PRE_NIB) begin
            rx_pcnt_r <= 5'h00;
          end else if (rx_pcnt_r >= det_thr - 5'h01) begin
            rx_st_r <= rs_sync;
            rx_shift_r <= 32'h00000000;
          end else begin
            rx_pcnt_r <= rx_pcnt_r + 5'h01;
          end
        end
        rs_sync: if (rx_nib_valid) begin
          rx_shift_r <= rx_shift_nxt;
          if (((rx_shift_nxt ^ sync_exp) & sync_mask) == 32'h0) begin
            rx_half_r <= 1'b0;
            rx_idx_r <= 2'h0;
            rx_cnt_r <= 8'h00;
            rx_hdr_r <= 32'h00000000;
            rx_st_r <= !rx_auto ? rs_data
              : (hdr_bytes != 3'h0) ? rs_hdr : rs_chk;
          end
        end
        rs_hdr: if (rx_byte_done) begin
          rx_hdr_r[{~rx_idx_r, 3'b000} +: 8] <= rx_byte;
          rx_idx_r <= rx_idx_r + 2'h1;
          if ({1'b0, rx_idx_r} == hdr_bytes - 3'h1) begin
            rx_st_r <= rs_chk;
          end
        end
        rs_chk: begin
          rx_len_r <= pkt_len_r;
          rx_st_r <= !hdr_pass ? rs_hunt : !fixlen ? rs_len
            : (pkt_len_r == 8'h00) ? rs_hunt : rs_data;
          rx_pcnt_r <= 5'h00;
        end
        rs_len: if (rx_byte_done) begin
          rx_len_r <= rx_byte;
          rx_st_r <= (rx_byte == 8'h00) ? rs_hunt : rs_data;
        end
        rs_data: if (rx_byte_done) begin
          rx_cnt_r <= rx_cnt_r + 8'h01;
          if (rx_auto && rx_cnt_r == rx_len_r - 8'h01) begin
            rx_st_r <= rs_hunt;
            rx_pcnt_r <= 5'h00;
          end
        end
        default: rx_st_r <= rs_hunt;
      endcase
    end
  end

  // Received payload output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_r <= 8'h00;
      rx_data_valid_r <= 1'b0;
    end else begin
      rx_data_valid_r <= rx_st_r == rs_data && rx_byte_done && !rx_restart;
      if (rx_st_r == rs_data && rx_byte_done) begin
        rx_data_r <= rx_byte;
      end
    end
  end
  assign rx_data = rx_data_r;
  assign rx_data_valid = rx_data_valid_r;
endmodule : rphc_framer

/* File: tb/rphc_framer_chk.sv */
// Checker: APB answers, nibble and byte handshakes.
// Assumes a bind into the framer; one clock.
`timescale 1ns/10ps
module rphc_framer_chk import rphc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Streams
  input wire logic tx_data_valid,
  input wire logic tx_data_ready,
  input wire logic [3:0] tx_nib,
  input wire logic tx_nib_valid,
  input wire logic tx_nib_ready,
  input wire logic rx_nib_valid,
  input wire logic rx_data_valid
);
  logic [9:0] idx;
  logic acc, mapped, narrow;
  // Decode of the addressed register
  assign idx = paddr[11:2];
  assign acc = psel && penable;
  assign mapped = (idx >= IDX_HDR_CHECK && idx <= IDX_SYNC1) ||
    (idx >= IDX_FRAME_CTRL && idx <= IDX_RX_HDR);
  assign narrow = mapped && idx != IDX_RX_HDR &&
    !(idx >= IDX_TX_HDR && idx <= IDX_HDR_MASK);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (acc |-> pready)
    else $error("pready low in access");
  bad_addr_a: assert property (acc && !mapped |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped answer");
  good_addr_a: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped register");
  err_place_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  rd_hold_a: assert property (!(psel && !penable && !pwrite) |=>
    $stable(prdata)) else $error("prdata moved without read");
  reg_width_a: assert property (acc && !pwrite && narrow |->
    prdata[31:8] == 24'h0) else $error("upper read bits set");
  nib_hold_a: assert property (tx_nib_valid && !tx_nib_ready |=>
    tx_nib_valid && $stable(tx_nib)) else $error("nibble dropped");
  rx_pulse_a: assert property (rx_data_valid |=> !rx_data_valid)
    else $error("byte pulse too long");
  rx_cause_a: assert property (rx_data_valid |-> $past(rx_nib_valid))
    else $error("byte without nibble");
  fifo_full_a: assert property ($fell(tx_data_ready) |->
    $past(tx_data_valid)) else $error("full without push");
  // Main scenarios
  cover property (rx_data_valid);
  cover property (acc && pslverr);
  cover property (tx_nib_valid && !tx_nib_ready);
  cover property (!tx_data_ready);
endmodule : rphc_framer_chk

bind rphc_framer rphc_framer_chk u_rphc_framer_chk (.*);

/* File: tb/rphc_remote.sv */
// Remote radio model: takes nibbles, echoes the frame on request.
// Assumes it shares pclk and framing setup with the framer.
`timescale 1ns/10ps
module rphc_remote (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Nibbles leaving the framer
  input wire logic [3:0] tx_nib,
  input wire logic tx_nib_valid,
  output logic tx_nib_ready,
  // Nibbles into the framer
  output logic [3:0] rx_nib,
  output logic rx_nib_valid
);
  logic [3:0] cap_q[$];
  // Idle line at start
  initial begin
    rx_nib = 4'h5;
    rx_nib_valid = 1'b0;
    tx_nib_ready = 1'b0;
  end
  // Collects nibbles, stalling at random
  always @(posedge pclk) begin
    if (tx_nib_valid === 1'b1 && tx_nib_ready) cap_q.push_back(tx_nib);
    tx_nib_ready <= presetn && ($urandom_range(3) != 0);
  end
  // Sends back the same frame with gaps; line toggles while idle
  task automatic replay();
    foreach (cap_q[i]) begin
      while ($urandom_range(3) == 0) begin
        rx_nib_valid <= 1'b0;
        rx_nib <= ~rx_nib;
        @(posedge pclk);
      end
      rx_nib <= cap_q[i];
      rx_nib_valid <= 1'b1;
      @(posedge pclk);
    end
    rx_nib_valid <= 1'b0;
    rx_nib <= ~cap_q[cap_q.size()-1];
  endtask : replay
endmodule : rphc_remote

/* File: tb/test_radio_packet_header_config.sv */
// Bench: resets, framed transmit, echoed receive, header checks.
// Assumes the remote model captures and echoes frames.
`timescale 1ns/10ps
module test_radio_packet_header_config import rphc_pkg::*; ;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, tx_start = 1'b0, tx_data_valid = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] tx_data = 8'h00, rx_data, rx_q[$];
  logic pready, pslverr, tx_data_ready, tx_nib_valid, tx_nib_ready;
  logic rx_nib_valid, rx_data_valid;
  logic [3:0] tx_nib, rx_nib, exp_q[$];
  int mismatches = 0, comparisons = 0;
  logic [9:0] ri[8] = '{IDX_HDR_CHECK, IDX_HDR_LEN, IDX_PRE_LOW,
    IDX_PRE_DET, IDX_SYNC3, IDX_SYNC2, IDX_SYNC1, 10'h3ff};
  logic [7:0] rv[8] = '{RST_HDR_CHECK, RST_HDR_LEN, RST_PRE_LOW,
    RST_PRE_DET, RST_SYNC3, RST_SYNC2, RST_SYNC1, 8'h00};
  // Clock and received byte log
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (rx_data_valid === 1'b1) rx_q.push_back(rx_data);
  // Framer and far side
  rphc_framer u_rphc_framer (.*, .rx_restart(1'b0));
  rphc_remote u_rphc_remote (.*);
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // One APB transfer, begun after a rising edge
  task automatic apb(input logic w, logic [9:0] i, logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) chk(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic void put(input logic [7:0] b);
    exp_q.push_back(b[7:4]);
    exp_q.push_back(b[3:0]);
  endfunction : put
  // Configure, send, echo back in packet mode only, check both ends
  task automatic run_cfg(input logic aut, logic [8:0] pre, logic [1:0] sl,
      logic [2:0] hl, logic fx, logic [3:0] hc, bc, logic [31:0] txh, cw,
      msk, logic [4:0] th);
    logic [31:0] pw, sy;
    logic [7:0] r;
    int h, s, n;
    bit ok, det;
    pw = $urandom();
    sy = {RST_SYNC3, RST_SYNC2, RST_SYNC1, RST_SYNC0};
    s = sl;
    h = (hl > 3'h4) ? 4 : hl;
    ok = 1'b1;
    det = aut && ((pre == 0) ? 1 : pre) >= ((th == 0) ? 1 : th);
    for (int i = 0; i < 4; i++) begin
      r = (i >= 4 - h) ? txh[8*i+:8] : 8'h00;
      if (hc[i] && ((r ^ cw[8*i+:8]) & msk[8*i+:8]) != 8'h00 &&
          !(bc[i] && r == BCAST_BYTE)) ok = 1'b0;
    end
    apb(1'b1, IDX_FRAME_CTRL, aut ? 32'h0b : 32'h08);
    apb(1'b1, IDX_HDR_CHECK, {24'h0, bc, hc});
    apb(1'b1, IDX_HDR_LEN, {24'h0, 1'b1, hl, fx, sl, pre[8]});
    apb(1'b0, IDX_HDR_LEN, '0);
    chk(rd, {25'h0, hl, fx, sl, pre[8]});
    apb(1'b1, IDX_PRE_LOW, {24'h0, pre[7:0]});
    apb(1'b1, IDX_PRE_DET, {24'h0, th, 3'h2});
    apb(1'b1, IDX_PKT_LEN, 32'h4);
    apb(1'b1, IDX_TX_HDR, txh);
    apb(1'b1, IDX_CHK_HDR, cw);
    apb(1'b1, IDX_HDR_MASK, msk);
    apb(1'b1, IDX_STATUS, 32'h7);
    for (int i = 0; i < 4; i++) begin
      tx_data <= pw[8*i+:8];
      tx_data_valid <= 1'b1;
      @(posedge pclk);
    end
    tx_data_valid <= 1'b0;
    #1 chk(tx_data_ready, 1'b0);
    exp_q.delete();
    if (aut) begin
      repeat ((pre == 0) ? 1 : pre) exp_q.push_back(PRE_NIB);
      for (int i = 3; i >= 3 - s; i--) put(sy[8*i+:8]);
      for (int i = 3; i >= 4 - h; i--) put(txh[8*i+:8]);
      if (!fx) put(8'h04);
    end
    for (int i = 0; i < 4; i++) put(pw[8*i+:8]);
    u_rphc_remote.cap_q.delete();
    @(posedge pclk);
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    n = 0;
    while (u_rphc_remote.cap_q.size() < exp_q.size() && n < 3000) begin
      n++;
      @(posedge pclk);
    end
    repeat (20) @(posedge pclk);
    chk(u_rphc_remote.cap_q.size(), exp_q.size());
    foreach (u_rphc_remote.cap_q[i]) chk(u_rphc_remote.cap_q[i], exp_q[i]);
    rx_q.delete();
    if (aut) u_rphc_remote.replay();
    n = 0;
    while (rx_q.size() < 4 && aut && n < 300) begin
      n++;
      @(posedge pclk);
    end
    repeat (10) @(posedge pclk);
    chk(rx_q.size(), (det && ok) ? 4 : 0);
    foreach (rx_q[i]) chk(rx_q[i], pw[8*i+:8]);
    apb(1'b0, IDX_STATUS, '0);
    chk(rd[2:0], {aut, det && !ok, det && ok});
  endtask : run_cfg
  // Cuts a hang short
  initial begin
    #200000;
    mismatches++;
    $display("ERROR %0t watchdog", $time);
    final_report();
  end
  // Main sequence
  initial begin
    void'($urandom(11));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 10'h3ff, '1);
    foreach (ri[i]) begin
      apb(1'b0, ri[i], '0);
      chk(rd, {24'h0, rv[i]});
      chk(er, i == 7);
    end
    run_cfg(1'b1, 9'h008, 2'h1, 3'h4, 1'b0, 4'h0, 4'h0, $urandom(),
      '0, '1, 5'h05);
    run_cfg(1'b1, 9'h000, 2'h3, 3'h0, 1'b1, 4'h0, 4'h0, $urandom(),
      '0, '0, 5'h05);
    run_cfg(1'b1, 9'h101, 2'h0, 3'h4, 1'b1, 4'h3, 4'h3, 32'h1234ffff,
      '0, '1, 5'h05);
    run_cfg(1'b1, 9'h006, 2'h2, 3'h4, 1'b0, 4'h4, 4'h0, 32'h11223344,
      32'h11203344, '1, 5'h05);
    run_cfg(1'b1, 9'h006, 2'h2, 3'h4, 1'b0, 4'hf, 4'h0, 32'h11223344,
      32'h11203344, 32'hfffdffff, 5'h05);
    run_cfg(1'b1, 9'h007, 2'h1, 3'h1, 1'b0, 4'h1, 4'h0, $urandom(),
      '0, '1, 5'h00);
    run_cfg(1'b1, 9'h008, 2'h1, 3'h4, 1'b0, 4'h0, 4'h0, $urandom(),
      '0, '0, 5'h1f);
    run_cfg(1'b0, 9'h008, 2'h1, 3'h4, 1'b0, 4'h0, 4'h0, $urandom(),
      '0, '0, 5'h05);
    repeat (3) run_cfg(1'b1, 9'h005 + 9'($urandom_range(15)),
      2'($urandom()), 3'($urandom()), 1'($urandom()), 4'($urandom()),
      4'($urandom()), $urandom(), $urandom(), $urandom(),
      5'h01 + 5'($urandom_range(4)));
    final_report();
  end
endmodule : test_radio_packet_header_config
